// [src/lookup_table_ram.sv]
// Lookup table storage with one byte-enabled write port and two read ports.
// Assumes all addresses arrive on the core clock; both reads take one cycle.
`timescale 1ns/1ps
module lookup_table_ram
    import upstream_window_lookup_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic we,
    input wire logic [LUT_IDX_W-1:0] waddr,
    input wire logic [STRB_W-1:0] wstrb,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic [LUT_IDX_W-1:0] raddr_a,
    output logic [DATA_W-1:0] qa,
    input wire logic [LUT_IDX_W-1:0] raddr_b,
    output logic [DATA_W-1:0] qb
);

    logic [DATA_W-1:0] mem [LUT_DEPTH];

    // Entries clear on reset so that every lookup starts out invalid.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            for (int i = 0; i < LUT_DEPTH; i++)
            begin
                mem[i] <= ZERO32;
            end
        end
        else if (we)
        begin
            for (int b = 0; b < STRB_W; b++)
            begin
                if (wstrb[b])
                    mem[waddr][8*b +: 8] <= wdata[8*b +: 8];
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            qa <= ZERO32;
            qb <= ZERO32;
        end
        else
        begin
            qa <= mem[raddr_a];
            qb <= mem[raddr_b];
        end
    end

endmodule // lookup_table_ram

// [src/masked_word_reg.sv]
// A 32-bit register whose writable bits and surviving bits are set by masks.
// Assumes the masks come from logic on the same clock.
`timescale 1ns/1ps
module masked_word_reg
    import upstream_window_lookup_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic we,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic [DATA_W-1:0] wmask,
    input wire logic [DATA_W-1:0] keep,
    output logic [DATA_W-1:0] q
);

    // Bits outside keep are forced to zero, so shrinking the size mask also
    // drops stale base bits instead of leaving them readable.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            q <= ZERO32;
        else if (we)
            q <= merge(q, wdata, wmask) & keep;
        else
            q <= q & keep;
    end

endmodule // masked_word_reg

// [src/upstream_window_lookup_config.sv]
// Upstream window 3 setup registers, its masked base registers and the
// indirect port into the upstream window 2 lookup table, on AXI4-Lite.
// Assumes one write and one read at most outstanding, and that the lookup
// index comes from logic on the same clock.
`timescale 1ns/1ps
module upstream_window_lookup_config
    import upstream_window_lookup_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [DATA_W-1:0] s_axi_wdata,
    input wire logic [STRB_W-1:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [LUT_IDX_W-1:0] lookup_index,
    output logic lookup_hit,
    output logic lookup_prefetch,
    output logic [DATA_W-1:0] lookup_base,
    output logic win3_prefetch,
    output logic [DATA_W-1:0] win3_size_mask,
    output logic win3_hi_enable,
    output logic [DATA_W-1:0] win3_base_lo,
    output logic [DATA_W-1:0] win3_base_hi
);

    typedef enum logic [2:0] {
        RD_IDLE = 3'b001,
        RD_FETCH = 3'b010,
        RD_RESP = 3'b100
    } rd_state_t;

    rd_state_t rd_state_r;
    logic [DATA_W-1:0] setup_r;
    logic [DATA_W-1:0] upper_r;
    logic page_32mb_r;
    logic [DATA_W-1:0] lut_ofs_r;
    logic aw_held_r;
    logic w_held_r;
    logic [ADDR_W-1:0] aw_addr_r;
    logic [DATA_W-1:0] w_data_r;
    logic [STRB_W-1:0] w_strb_r;
    logic [ADDR_W-1:0] rd_addr_r;
    logic [DATA_W-1:0] rdata_nxt;
    logic [1:0] rresp_nxt;
    logic [1:0] bresp_nxt;
    logic wr_go;
    logic ar_take;
    logic [ADDR_W-1:0] wa;
    logic [ADDR_W-1:0] ra;
    logic [DATA_W-1:0] wmask;
    logic [DATA_W-1:0] setup_view;
    logic [DATA_W-1:0] lut_wdata;
    logic lut_we;
    logic [LUT_IDX_W-1:0] lut_waddr;
    logic [LUT_IDX_W-1:0] lut_raddr;
    logic [DATA_W-1:0] lut_qa;
    logic [DATA_W-1:0] lut_qb;
    logic base_lo_we;
    logic base_hi_we;
    logic [DATA_W-1:0] lo_keep;
    logic [DATA_W-1:0] hi_keep;

    assign wr_go = aw_held_r && w_held_r && !s_axi_bvalid;
    assign ar_take = s_axi_arvalid && s_axi_arready;
    assign wa = word_addr(aw_addr_r);
    assign ra = word_addr(rd_addr_r);
    assign wmask = strobe_mask(w_strb_r);
    assign setup_view = (setup_r & SETUP_RW_MASK) | SETUP_FIXED;

    // Write channel capture: address and data are held independently, so
    // either may arrive first; both ready flags drop until the response is taken.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_r <= 1'b0;
            aw_addr_r <= '0;
            s_axi_awready <= 1'b1;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_held_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end
        else if (wr_go)
            aw_held_r <= 1'b0;
        else if (s_axi_bvalid && s_axi_bready)
            s_axi_awready <= 1'b1;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_held_r <= 1'b0;
            w_data_r <= ZERO32;
            w_strb_r <= '0;
            s_axi_wready <= 1'b1;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_held_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end
        else if (wr_go)
            w_held_r <= 1'b0;
        else if (s_axi_bvalid && s_axi_bready)
            s_axi_wready <= 1'b1;
    end

    always_comb
    begin
        bresp_nxt = RESP_OKAY;
        unique case (wa)
            OFF_SETUP, OFF_UPPER, OFF_PAGE, OFF_BASE_LO, OFF_BASE_HI,
            OFF_LUT_OFS, OFF_LUT_DATA: bresp_nxt = RESP_OKAY;
            default: bresp_nxt = in_lut_window(wa) ? RESP_OKAY : RESP_SLVERR;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end
        else if (wr_go)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= bresp_nxt;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // Only the writable setup bits are stored; the fixed ones are merged on read.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            setup_r <= ZERO32;
        else if (wr_go && wa == OFF_SETUP)
            setup_r <= merge(setup_r, w_data_r, wmask & SETUP_RW_MASK);
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            upper_r <= ZERO32;
        else if (wr_go && wa == OFF_UPPER)
            upper_r <= merge(upper_r, w_data_r, wmask);
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            page_32mb_r <= 1'b0;
        else if (wr_go && wa == OFF_PAGE && w_strb_r[0])
            page_32mb_r <= w_data_r[PAGE_32MB_BIT];
    end

    // Writing the offset only moves the pointer; the table itself is not read.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            lut_ofs_r <= ZERO32;
        else if (wr_go && wa == OFF_LUT_OFS)
            lut_ofs_r <= merge(lut_ofs_r, w_data_r, wmask & LUT_OFS_MASK);
    end

    assign lo_keep = setup_r & SETUP_SIZE_MASK;
    assign hi_keep = upper_r[UPPER_EN_BIT] ? (UPPER_EN_MASK | (upper_r & UPPER_SIZE_MASK))
                                           : ZERO32;
    assign base_lo_we = wr_go && wa == OFF_BASE_LO;
    assign base_hi_we = wr_go && wa == OFF_BASE_HI;

    masked_word_reg u_base_lo (
        .aclk(aclk),
        .aresetn(aresetn),
        .we(base_lo_we),
        .wdata(w_data_r),
        .wmask(wmask & lo_keep),
        .keep(lo_keep),
        .q(win3_base_lo)
    );

    masked_word_reg u_base_hi (
        .aclk(aclk),
        .aresetn(aresetn),
        .we(base_hi_we),
        .wdata(w_data_r),
        .wmask(wmask & hi_keep),
        .keep(hi_keep),
        .q(win3_base_hi)
    );

    // The data register reaches the entry named by the offset; the direct
    // window reaches the entry named by the bus address itself.
    assign lut_we = wr_go && (wa == OFF_LUT_DATA || in_lut_window(wa));
    assign lut_waddr = (wa == OFF_LUT_DATA) ? lut_ofs_r[IDX_LSB +: LUT_IDX_W]
                                            : wa[IDX_LSB +: LUT_IDX_W];
    assign lut_wdata = w_data_r & entry_mask(page_32mb_r);
    assign lut_raddr = (word_addr(s_axi_araddr) == OFF_LUT_DATA)
                       ? lut_ofs_r[IDX_LSB +: LUT_IDX_W]
                       : s_axi_araddr[IDX_LSB +: LUT_IDX_W];

    lookup_table_ram u_lut (
        .aclk(aclk),
        .aresetn(aresetn),
        .we(lut_we),
        .waddr(lut_waddr),
        .wstrb(w_strb_r),
        .wdata(lut_wdata),
        .raddr_a(lut_raddr),
        .qa(lut_qa),
        .raddr_b(lookup_index),
        .qb(lut_qb)
    );

    // Read path: the table is sampled at the address edge, so the answer is
    // formed one cycle later for every register alike.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rd_state_r <= RD_IDLE;
            rd_addr_r <= '0;
            s_axi_arready <= 1'b1;
        end
        else
        begin
            unique case (rd_state_r)
                RD_IDLE:
                begin
                    if (ar_take)
                    begin
                        rd_addr_r <= s_axi_araddr;
                        s_axi_arready <= 1'b0;
                        rd_state_r <= RD_FETCH;
                    end
                end
                RD_FETCH: rd_state_r <= RD_RESP;
                RD_RESP:
                begin
                    if (s_axi_rready)
                    begin
                        s_axi_arready <= 1'b1;
                        rd_state_r <= RD_IDLE;
                    end
                end
            endcase
        end
    end

    always_comb
    begin
        rdata_nxt = ZERO32;
        rresp_nxt = RESP_OKAY;
        unique case (ra)
            OFF_SETUP: rdata_nxt = setup_view;
            OFF_UPPER: rdata_nxt = upper_r;
            OFF_PAGE: rdata_nxt = {{(DATA_W-1){1'b0}}, page_32mb_r};
            OFF_BASE_LO: rdata_nxt = win3_base_lo | (setup_view & SETUP_ATTR_MASK);
            OFF_BASE_HI: rdata_nxt = win3_base_hi;
            OFF_LUT_OFS: rdata_nxt = lut_ofs_r & LUT_OFS_MASK;
            OFF_LUT_DATA: rdata_nxt = lut_qa & entry_mask(page_32mb_r);
            default:
            begin
                if (in_lut_window(ra))
                    rdata_nxt = lut_qa & entry_mask(page_32mb_r);
                else
                    rresp_nxt = RESP_SLVERR;
            end
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= ZERO32;
            s_axi_rresp <= RESP_OKAY;
        end
        else if (rd_state_r == RD_FETCH)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdata_nxt;
            s_axi_rresp <= rresp_nxt;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // Translation outputs: an entry with its valid flag low never hits.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            lookup_hit <= 1'b0;
            lookup_prefetch <= 1'b0;
            lookup_base <= ZERO32;
        end
        else
        begin
            lookup_hit <= lut_qb[ENTRY_VALID_BIT];
            lookup_prefetch <= lut_qb[ENTRY_VALID_BIT] && lut_qb[ENTRY_PREF_BIT];
            lookup_base <= lut_qb[ENTRY_VALID_BIT]
                           ? (lut_qb & entry_mask(page_32mb_r) & ENTRY_BASE_MASK)
                           : ZERO32;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            win3_prefetch <= 1'b0;
            win3_size_mask <= ZERO32;
            win3_hi_enable <= 1'b0;
        end
        else
        begin
            win3_prefetch <= setup_r[SETUP_PREF_BIT];
            win3_size_mask <= setup_r & SETUP_SIZE_MASK;
            win3_hi_enable <= upper_r[UPPER_EN_BIT];
        end
    end

endmodule // upstream_window_lookup_config

// [src/upstream_window_lookup_pkg.sv]
// Constants, register map and helper functions for the upstream window 3 setup
// and window 2 lookup table configuration block.
// Assumes a single 100 MHz core clock and an AXI4-Lite register master.
package upstream_window_lookup_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int STRB_W = 4;
    localparam int LUT_DEPTH = 64;
    localparam int LUT_IDX_W = 6;
    localparam int IDX_LSB = 2;
    localparam int SIZE_LSB = 12;

    localparam logic [ADDR_W-1:0] OFF_SETUP = 12'h034;
    localparam logic [ADDR_W-1:0] OFF_UPPER = 12'h038;
    localparam logic [ADDR_W-1:0] OFF_PAGE = 12'h040;
    localparam logic [ADDR_W-1:0] OFF_BASE_LO = 12'h044;
    localparam logic [ADDR_W-1:0] OFF_BASE_HI = 12'h048;
    localparam logic [ADDR_W-1:0] OFF_LUT_OFS = 12'h050;
    localparam logic [ADDR_W-1:0] OFF_LUT_DATA = 12'h054;
    localparam logic [3:0] LUT_WINDOW_PAGE = 4'h1;

    localparam logic [DATA_W-1:0] ZERO32 = 32'h0000_0000;
    localparam logic [DATA_W-1:0] SETUP_FIXED = 32'h0000_0002;
    localparam logic [DATA_W-1:0] SETUP_RW_MASK = 32'hFFFF_F008;
    localparam logic [DATA_W-1:0] SETUP_SIZE_MASK = 32'hFFFF_F000;
    localparam logic [DATA_W-1:0] SETUP_ATTR_MASK = 32'h0000_000F;
    localparam logic [DATA_W-1:0] UPPER_SIZE_MASK = 32'h7FFF_FFFF;
    localparam logic [DATA_W-1:0] UPPER_EN_MASK = 32'h8000_0000;
    localparam int UPPER_EN_BIT = 31;
    localparam int SETUP_PREF_BIT = 3;
    localparam logic [DATA_W-1:0] PAGE_RW_MASK = 32'h0000_0001;
    localparam int PAGE_32MB_BIT = 0;
    localparam logic [DATA_W-1:0] LUT_OFS_MASK = 32'h0000_00FF;
    localparam logic [DATA_W-1:0] ENTRY_ALWAYS_MASK = 32'hFE00_0009;
    localparam logic [DATA_W-1:0] ENTRY_FINE_MASK = 32'h01FF_FF00;
    localparam logic [DATA_W-1:0] ENTRY_BASE_MASK = 32'hFFFF_FF00;
    localparam int ENTRY_VALID_BIT = 0;
    localparam int ENTRY_PREF_BIT = 3;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    function automatic logic [DATA_W-1:0] strobe_mask(input logic [STRB_W-1:0] strb);
        logic [DATA_W-1:0] m;
        m = ZERO32;
        for (int i = 0; i < STRB_W; i++)
        begin
            m[8*i +: 8] = {8{strb[i]}};
        end
        return m;
    endfunction

    function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_v,
                                                input logic [DATA_W-1:0] new_v,
                                                input logic [DATA_W-1:0] m);
        return (old_v & ~m) | (new_v & m);
    endfunction

    function automatic logic [DATA_W-1:0] entry_mask(input logic page_32mb);
        return page_32mb ? ENTRY_ALWAYS_MASK : (ENTRY_ALWAYS_MASK | ENTRY_FINE_MASK);
    endfunction

    function automatic logic [ADDR_W-1:0] word_addr(input logic [ADDR_W-1:0] a);
        return {a[ADDR_W-1:IDX_LSB], 2'h0};
    endfunction

    function automatic logic in_lut_window(input logic [ADDR_W-1:0] a);
        return a[ADDR_W-1:8] == LUT_WINDOW_PAGE;
    endfunction

endpackage

// [tb/tb_top.sv]
// Self-checking bench for the window setup and lookup table block.
// Assumes the block is reached over AXI4-Lite alone; protection inputs are unused.
`timescale 1ns/1ps
module tb_top
    import upstream_window_lookup_pkg::*;
;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic s_axi_rready, lookup_hit, lookup_prefetch, win3_prefetch, win3_hi_enable;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata, lookup_base, win3_size_mask;
    logic [DATA_W-1:0] win3_base_lo, win3_base_hi;
    logic [STRB_W-1:0] s_axi_wstrb;
    logic [LUT_IDX_W-1:0] lookup_index;
    logic [2:0] s_axi_awprot, s_axi_arprot;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int bad_count, n_tests;

    upstream_window_lookup_config dut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .lookup_index, .lookup_hit, .lookup_prefetch, .lookup_base, .win3_prefetch,
        .win3_size_mask, .win3_hi_enable, .win3_base_lo, .win3_base_hi
    );

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // A wait that runs out ends the run rather than hanging it.
    task automatic guard(input int n);
        if (n >= 200)
        begin
            bad_count++;
            final_report();
        end
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                      input logic [1:0] r);
        int n;
        logic aw_p;
        logic w_p;
        n = 0;
        aw_p = 1'b1;
        w_p = 1'b1;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while ((aw_p || w_p) && n < 200)
        begin
            @(posedge aclk);
            n++;
            if (aw_p && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (w_p && s_axi_wready)
                s_axi_wvalid <= 1'b0;
            aw_p = aw_p && !s_axi_awready;
            w_p = w_p && !s_axi_wready;
        end
        do
        begin
            @(posedge aclk);
            n++;
        end
        while (!s_axi_bvalid && n < 200);
        s_axi_bready <= 1'b0;
        guard(n);
        check(32'(s_axi_bresp), 32'(r));
        // Register outputs follow the write by one edge, so let it pass first.
        @(posedge aclk);
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e,
                      input logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
        end
        while (!s_axi_arready && n < 200);
        s_axi_arvalid <= 1'b0;
        do
        begin
            @(posedge aclk);
            n++;
        end
        while (!s_axi_rvalid && n < 200);
        s_axi_rready <= 1'b0;
        guard(n);
        check(s_axi_rdata, e);
        check(32'(s_axi_rresp), 32'(r));
    endtask

    // Base low bits are always zero, so hit and prefetch ride in bits 0 and 1.
    task automatic look(input logic [LUT_IDX_W-1:0] i, input logic [DATA_W-1:0] e);
        @(posedge aclk);
        lookup_index <= i;
        repeat (3) @(posedge aclk);
        check({lookup_base[31:2], lookup_prefetch, lookup_hit}, e);
    endtask

    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    initial
    begin
        bad_count = 0;
        n_tests = 0;
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        s_axi_awaddr = 12'h000;
        s_axi_araddr = 12'h000;
        s_axi_wdata = ZERO32;
        s_axi_wstrb = 4'hF;
        s_axi_awprot = 3'h0;
        s_axi_arprot = 3'h0;
        lookup_index = 6'h00;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rd(OFF_SETUP, 32'h0000_0002, RESP_OKAY);
        rd(OFF_UPPER, ZERO32, RESP_OKAY);
        rd(OFF_LUT_OFS, ZERO32, RESP_OKAY);
        wr(OFF_SETUP, 32'hFFFF_FFFF, RESP_OKAY);
        rd(OFF_SETUP, 32'hFFFF_F00A, RESP_OKAY);
        check(32'(win3_prefetch), 32'h0000_0001);
        check(win3_size_mask, 32'hFFFF_F000);
        wr(OFF_SETUP, 32'hFFFF_0000, RESP_OKAY);
        check(32'(win3_prefetch), ZERO32);
        wr(OFF_BASE_LO, 32'hFFFF_FFFF, RESP_OKAY);
        rd(OFF_BASE_LO, 32'hFFFF_0002, RESP_OKAY);
        check(win3_base_lo, 32'hFFFF_0000);
        s_axi_wstrb <= 4'h1;
        wr(OFF_SETUP, 32'h0000_FF08, RESP_OKAY);
        s_axi_wstrb <= 4'hF;
        rd(OFF_SETUP, 32'hFFFF_000A, RESP_OKAY);
        wr(OFF_UPPER, 32'h0000_FFFF, RESP_OKAY);
        wr(OFF_BASE_HI, 32'hFFFF_FFFF, RESP_OKAY);
        rd(OFF_BASE_HI, ZERO32, RESP_OKAY);
        check(32'(win3_hi_enable), ZERO32);
        wr(OFF_UPPER, 32'h8000_FFFF, RESP_OKAY);
        rd(OFF_UPPER, 32'h8000_FFFF, RESP_OKAY);
        wr(OFF_BASE_HI, 32'hFFFF_FFFF, RESP_OKAY);
        rd(OFF_BASE_HI, 32'h8000_FFFF, RESP_OKAY);
        check(win3_base_hi, 32'h8000_FFFF);
        wr(OFF_UPPER, ZERO32, RESP_OKAY);
        check(win3_base_hi, ZERO32);
        wr(OFF_LUT_OFS, 32'hFFFF_FF08, RESP_OKAY);
        rd(OFF_LUT_OFS, 32'h0000_0008, RESP_OKAY);
        wr(OFF_LUT_DATA, 32'hFFFF_FFFF, RESP_OKAY);
        rd(OFF_LUT_DATA, 32'hFFFF_FF09, RESP_OKAY);
        rd(12'h108, 32'hFFFF_FF09, RESP_OKAY);
        look(6'h02, 32'hFFFF_FF03);
        wr(OFF_LUT_OFS, 32'h0000_000C, RESP_OKAY);
        rd(OFF_LUT_DATA, ZERO32, RESP_OKAY);
        rd(12'h108, 32'hFFFF_FF09, RESP_OKAY);
        wr(12'h10C, 32'h0000_0008, RESP_OKAY);
        rd(OFF_LUT_DATA, 32'h0000_0008, RESP_OKAY);
        look(6'h03, ZERO32);
        wr(OFF_LUT_DATA, 32'h0200_0001, RESP_OKAY);
        look(6'h03, 32'h0200_0001);
        wr(OFF_PAGE, 32'h0000_0001, RESP_OKAY);
        wr(OFF_LUT_OFS, 32'h0000_0008, RESP_OKAY);
        rd(OFF_LUT_DATA, 32'hFE00_0009, RESP_OKAY);
        look(6'h02, 32'hFE00_0003);
        wr(12'h200, 32'hFFFF_FFFF, RESP_SLVERR);
        rd(12'h03C, ZERO32, RESP_SLVERR);
        final_report();
    end
endmodule // tb_top

// [tb/window_lookup_monitor.sv]
// Concurrent checks on the window setup and lookup table block.
// Assumes it sees only the top module's ports, attached by the bind below.
`timescale 1ns/1ps
module window_lookup_monitor
    import upstream_window_lookup_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic [DATA_W-1:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_bvalid,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_rvalid,
    input wire logic [DATA_W-1:0] s_axi_rdata,
    input wire logic [LUT_IDX_W-1:0] lookup_index,
    input wire logic lookup_hit,
    input wire logic lookup_prefetch,
    input wire logic [DATA_W-1:0] lookup_base,
    input wire logic win3_prefetch,
    input wire logic [DATA_W-1:0] win3_size_mask,
    input wire logic win3_hi_enable,
    input wire logic [DATA_W-1:0] win3_base_hi,
    input wire logic [DATA_W-1:0] win3_base_lo
);
    logic [ADDR_W-1:0] wa_r;
    logic [ADDR_W-1:0] ra_r;
    logic [DATA_W-1:0] wd_r;
    // Payloads are held while valid, so capturing on valid alone is enough.
    always_ff @(posedge aclk)
    begin
        if (s_axi_awvalid)
            wa_r <= s_axi_awaddr;
        if (s_axi_wvalid)
            wd_r <= s_axi_wdata;
        if (s_axi_arvalid)
            ra_r <= s_axi_araddr;
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_setup_fixed;
        $rose(s_axi_rvalid) && ra_r == OFF_SETUP |-> s_axi_rdata[2:0] == 3'h2;
    endproperty
    a_setup_fixed: assert property (p_setup_fixed) else $error("setup low bits wrong");
    property p_ofs_read;
        $rose(s_axi_rvalid) && ra_r == OFF_LUT_OFS |-> s_axi_rdata[31:8] == 24'h0;
    endproperty
    a_ofs_read: assert property (p_ofs_read) else $error("offset upper bits set");
    property p_entry_rsvd;
        $rose(s_axi_rvalid) && ra_r == OFF_LUT_DATA |-> s_axi_rdata[7:4] == 4'h0
            && s_axi_rdata[2:1] == 2'h0;
    endproperty
    a_entry_rsvd: assert property (p_entry_rsvd) else $error("entry spare bits set");
    property p_prefetch;
        $rose(s_axi_bvalid) && wa_r == OFF_SETUP |-> ##[0:2] win3_prefetch == wd_r[3];
    endproperty
    a_prefetch: assert property (p_prefetch) else $error("prefetch flag stale");
    property p_hi_off;
        !win3_hi_enable [*3] |-> win3_base_hi == ZERO32;
    endproperty
    a_hi_off: assert property (p_hi_off) else $error("upper base live while off");
    property p_lo_mask;
        $stable(win3_size_mask) [*3] |-> (win3_base_lo & ~win3_size_mask) == ZERO32;
    endproperty
    a_lo_mask: assert property (p_lo_mask) else $error("base bit outside size");
    property p_miss_clear;
        !lookup_hit |-> lookup_base == ZERO32 && !lookup_prefetch;
    endproperty
    a_miss_clear: assert property (p_miss_clear) else $error("invalid entry used");
    property p_ofs_quiet;
        $stable(lookup_index) [*4] ##0 ($rose(s_axi_bvalid) && wa_r == OFF_LUT_OFS)
            |-> $stable(lookup_base) && $stable(lookup_hit);
    endproperty
    a_ofs_quiet: assert property (p_ofs_quiet) else $error("offset write moved table");
    cover property ($rose(lookup_hit));
    cover property ($rose(win3_hi_enable));
    cover property ($rose(s_axi_rvalid) && ra_r == OFF_LUT_DATA);
endmodule // window_lookup_monitor

bind upstream_window_lookup_config window_lookup_monitor mon (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_wdata, .s_axi_wvalid,
    .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_rvalid, .s_axi_rdata,
    .lookup_index, .lookup_hit, .lookup_prefetch, .lookup_base, .win3_prefetch,
    .win3_size_mask, .win3_hi_enable, .win3_base_hi, .win3_base_lo
);
